// File: bench/master_model.sv
`timescale 1ns/1ps
`default_nettype none
module master_model (
  // Clock
  input wire logic clk,
  // Bus pins
  output logic chip_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic select_addr0,
  output logic select_addr1,
  output logic [7:0] master_data_in,
  input wire logic [7:0] master_data_out,
  input wire logic master_data_oe
);
  // ****************************************
  // Bus cycles, strobes held well over 3 clocks
  // ****************************************
  initial {chip_select_n, read_strobe_n, write_strobe_n, select_addr1, select_addr0} = 5'h1C;
  initial master_data_in = 8'h00;
  task automatic mwrite(input logic [1:0] sel, input logic [7:0] data);
    @(posedge clk);
    #2;
    {select_addr1, select_addr0} = sel;
    master_data_in = data;
    chip_select_n = 1'b0;
    write_strobe_n = 1'b0;
    repeat (4) @(posedge clk);
    #2;
    chip_select_n = 1'b1;
    write_strobe_n = 1'b1;
    @(posedge clk);
    #2;
    master_data_in = ~data;
    repeat (4) @(posedge clk);
  endtask : mwrite
  task automatic mread(input logic [1:0] sel, output logic [7:0] data, output logic oe);
    @(posedge clk);
    #2;
    {select_addr1, select_addr0} = sel;
    chip_select_n = 1'b0;
    read_strobe_n = 1'b0;
    repeat (6) @(posedge clk);
    #2;
    data = master_data_out;
    oe = master_data_oe;
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
    repeat (5) @(posedge clk);
  endtask : mread
endmodule : master_model
`default_nettype wire

// File: bench/slave_port_mailbox_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module mailbox_chk
  import mailbox_pkg::*;
#(
  parameter int DEPTH = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Slave access
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  // Status outputs
  input wire logic attention_out_n,
  input wire logic slave_irq,
  input wire logic [1:0] irq_priority,
  input wire logic cold_boot_active,
  input wire logic run_from_zero,
  input wire logic slave_port_enabled,
  input wire logic port_a_output,
  input wire logic boot_pins_obeyed
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire ctl_wr = io_wr && io_addr == ADDR_CONTROL;
  wire ctl_rd = io_rd && io_addr == ADDR_CONTROL;
  wire unmapped_rd = io_rd && (io_addr < ADDR_DATA_0 || io_addr > ADDR_CONTROL);
  attn_idle_a: assert property ($fell(rst) |-> attention_out_n)
    else $error("attention low after reset");
  attn_set_a: assert property (io_wr && io_addr == ADDR_DATA_0 |=> !attention_out_n)
    else $error("attention not driven low");
  irq_gate_a: assert property (slave_irq |-> irq_priority != 2'h0)
    else $error("interrupt with priority zero");
  port_en_a: assert property (ctl_wr |=> slave_port_enabled == $past(io_wdata[CTL_PORT_EN]))
    else $error("port enable not written");
  port_dir_a: assert property (ctl_wr |=> port_a_output == ($past(io_wdata[3:2]) == 2'h1))
    else $error("port A direction wrong");
  pins_obey_a: assert property (ctl_wr |=> boot_pins_obeyed == !$past(io_wdata[CTL_IGNORE_PINS]))
    else $error("boot pin obey wrong");
  prio_set_a: assert property (ctl_wr |=> irq_priority == $past(io_wdata[1:0]))
    else $error("priority not written");
  ctl_read_a: assert property (ctl_rd |=> ##1 io_rdata[4] == 1'b0 && io_rdata[3] == slave_port_enabled
    && io_rdata[1:0] == irq_priority)
    else $error("control readback wrong");
  unmapped_a: assert property (unmapped_rd |=> ##1 io_rdata == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!$past(io_rd) |=> $stable(io_rdata))
    else $error("read data changed without read");
  boot_end_a: assert property ($fell(cold_boot_active) |-> ##[0:1] run_from_zero)
    else $error("no start pulse at boot end");
endmodule : mailbox_chk
`default_nettype wire

// File: bench/test_slave_port_mailbox_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_slave_port_mailbox_regs
  import mailbox_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] io_addr = 8'h00;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic [7:0] io_rdata, master_data_in, master_data_out;
  logic chip_select_n, read_strobe_n, write_strobe_n, select_addr0, select_addr1, master_data_oe;
  logic boot_mode_pin0 = 1'b0;
  logic boot_mode_pin1 = 1'b0;
  logic attention_out_n, slave_irq, cold_boot_active, run_from_zero;
  logic slave_port_enabled, port_a_output, boot_pins_obeyed;
  logic [1:0] irq_priority;
  int fail_count = 0;
  int comparisons = 0;
  // ****************************************
  // Clock, design and master
  // ****************************************
  initial forever #12.5 clk = ~clk;
  slave_port_mailbox_regs #(.DEPTH(3)) slave_port_mailbox_regs_inst (.clk(clk), .rst(rst),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .select_addr0(select_addr0), .select_addr1(select_addr1), .master_data_in(master_data_in),
    .master_data_out(master_data_out), .master_data_oe(master_data_oe),
    .boot_mode_pin0(boot_mode_pin0), .boot_mode_pin1(boot_mode_pin1),
    .attention_out_n(attention_out_n), .slave_irq(slave_irq), .irq_priority(irq_priority),
    .cold_boot_active(cold_boot_active), .run_from_zero(run_from_zero),
    .slave_port_enabled(slave_port_enabled), .port_a_output(port_a_output),
    .boot_pins_obeyed(boot_pins_obeyed));
  master_model master_model_inst (.clk(clk), .chip_select_n(chip_select_n),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .select_addr0(select_addr0),
    .select_addr1(select_addr1), .master_data_in(master_data_in),
    .master_data_out(master_data_out), .master_data_oe(master_data_oe));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic test_done();
    if (fail_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask : chk
  task automatic do_reset();
    @(posedge clk);
    #2;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #2;
    rst = 1'b0;
  endtask : do_reset
  task automatic swr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    #2;
    io_addr = addr;
    io_wdata = data;
    io_wr = 1'b1;
    @(posedge clk);
    #2;
    io_wr = 1'b0;
  endtask : swr
  task automatic srd(input logic [7:0] addr, input logic [7:0] exp);
    @(posedge clk);
    #2;
    io_addr = addr;
    io_rd = 1'b1;
    @(posedge clk);
    #2;
    io_rd = 1'b0;
    @(posedge clk);
    #2;
    chk("io_rdata", exp, io_rdata);
  endtask : srd
  task automatic mrd(input logic [1:0] sel, input logic [7:0] exp);
    logic [7:0] d;
    logic oe;
    master_model_inst.mread(sel, d, oe);
    chk("master_data_out", exp, d);
    chk("master_data_oe", 8'h01, {7'h00, oe});
  endtask : mrd
  function automatic logic [7:0] outs();
    return {3'h0, boot_pins_obeyed, slave_port_enabled, port_a_output, irq_priority};
  endfunction : outs
  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    #(25 * 20000);
    fail_count++;
    test_done();
  end
  initial
  begin
    int n;
    do_reset();
    chk("attention_out_n", 8'h01, {7'h00, attention_out_n});
    srd(ADDR_FLAGS, 8'h00);
    swr(ADDR_CONTROL, 8'hFF);
    srd(ADDR_CONTROL, 8'h8F);
    chk("outputs", 8'h0B, outs());
    for (n = 0; n < 4; n++)
    begin
      swr(ADDR_CONTROL, 8'h04 | 8'(n));
      chk("outputs", 8'h14 | 8'(n), outs());
    end
    swr(ADDR_CONTROL, 8'h08);
    for (n = 0; n < 3; n++)
      swr(ADDR_DATA_0 + 8'(n), 8'hA0 + 8'(n));
    chk("attention_out_n", 8'h00, {7'h00, attention_out_n});
    srd(ADDR_FLAGS, 8'hF0);
    for (n = 0; n < 3; n++)
      mrd(2'(n), 8'hA0 + 8'(n));
    mrd(SEL_FLAGS, 8'h80);
    master_model_inst.mwrite(SEL_FLAGS, 8'h55);
    chk("attention_out_n", 8'h01, {7'h00, attention_out_n});
    srd(ADDR_FLAGS, 8'h00);
    for (n = 0; n < 3; n++)
      master_model_inst.mwrite(2'(n), 8'h50 + 8'(n));
    srd(ADDR_FLAGS, 8'h0F);
    chk("slave_irq", 8'h00, {7'h00, slave_irq});
    swr(ADDR_CONTROL, 8'h0A);
    chk("slave_irq", 8'h01, {7'h00, slave_irq});
    master_model_inst.mwrite(SEL_FLAGS, 8'h00);
    srd(ADDR_FLAGS, 8'h0F);
    for (n = 0; n < 3; n++)
      srd(ADDR_DATA_0 + 8'(n), 8'h50 + 8'(n));
    srd(ADDR_FLAGS, 8'h08);
    srd(ADDR_FLAGS, 8'h08);
    swr(ADDR_FLAGS, 8'hFF);
    srd(ADDR_FLAGS, 8'h00);
    chk("slave_irq", 8'h00, {7'h00, slave_irq});
    swr(8'h25, 8'h77);
    srd(8'h25, 8'h00);
    boot_mode_pin0 = 1'b1;
    repeat (3) @(posedge clk);
    do_reset();
    repeat (3) @(posedge clk);
    #2;
    chk("cold_boot_active", 8'h01, {7'h00, cold_boot_active});
    srd(ADDR_CONTROL, 8'h28);
    master_model_inst.mwrite(SEL_DATA_0, 8'h3C);
    srd(ADDR_DATA_0, 8'h3C);
    boot_mode_pin0 = 1'b0;
    for (n = 0; n < 20 && run_from_zero !== 1'b1; n++)
      @(posedge clk);
    chk("run_from_zero", 8'h01, {7'h00, run_from_zero});
    repeat (2) @(posedge clk);
    chk("cold_boot_active", 8'h00, {7'h00, cold_boot_active});
    test_done();
  end
endmodule : test_slave_port_mailbox_regs
bind slave_port_mailbox_regs mailbox_chk #(.DEPTH(DEPTH)) mailbox_chk_inst (.clk(clk), .rst(rst),
  .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
  .attention_out_n(attention_out_n), .slave_irq(slave_irq), .irq_priority(irq_priority),
  .cold_boot_active(cold_boot_active), .run_from_zero(run_from_zero),
  .slave_port_enabled(slave_port_enabled), .port_a_output(port_a_output),
  .boot_pins_obeyed(boot_pins_obeyed));
`default_nettype wire

// File: rtl/mailbox_bank.sv
`timescale 1ns/1ps
`default_nettype none
module mailbox_bank
  import mailbox_pkg::*;
#(
  parameter int DEPTH = 3,
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Write side
  input wire logic wr_en,
  input wire logic [1:0] wr_sel,
  input wire logic [WIDTH-1:0] wr_data,
  // Read side
  input wire logic [1:0] rd_sel,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  // ****************************************************************
  // One writer, one reader per bank
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++)
    begin : g_word
      always_ff @(posedge clk)
      begin
        if (rst)
          mem_reg[i] <= DATA_RESET;
        else if (wr_en && wr_sel == 2'(i))
          mem_reg[i] <= wr_data;
      end
    end
  endgenerate
  wire logic sel_ok = (32'(rd_sel) < DEPTH);
  always_ff @(posedge clk)
  begin
    if (rst)
      rd_data <= DATA_RESET;
    else if (sel_ok)
      rd_data <= mem_reg[rd_sel];
    else
      rd_data <= DATA_RESET;
  end
endmodule : mailbox_bank
`default_nettype wire

// File: rtl/mailbox_pkg.sv
package mailbox_pkg;
  // ****************************************************************
  // Slave-side internal I/O map
  // ****************************************************************
  localparam logic [7:0] ADDR_DATA_0 = 8'h20;
  localparam logic [7:0] ADDR_DATA_1 = 8'h21;
  localparam logic [7:0] ADDR_DATA_2 = 8'h22;
  localparam logic [7:0] ADDR_FLAGS = 8'h23;
  localparam logic [7:0] ADDR_CONTROL = 8'h24;
  // ****************************************************************
  // Master-side select codes
  // ****************************************************************
  localparam logic [1:0] SEL_DATA_0 = 2'h0;
  localparam logic [1:0] SEL_DATA_2 = 2'h2;
  localparam logic [1:0] SEL_FLAGS = 2'h3;
  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int CTL_IGNORE_PINS = 7;
  localparam int CTL_PIN1 = 6;
  localparam int CTL_PIN0 = 5;
  localparam int CTL_PORT_EN = 3;
  localparam int CTL_PORTA_OUT = 2;
  localparam int CTL_PRIO_HI = 1;
  localparam int CTL_PRIO_LO = 0;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CTL_WRITE_MASK = 8'h8F;
  // ****************************************************************
  // Status register fields
  // ****************************************************************
  localparam int FLG_ATTN = 7;
  localparam int FLG_OUT_FULL0 = 4;
  localparam int FLG_IN_INT = 3;
  localparam int FLG_IN_FULL0 = 0;
  // ****************************************************************
  // Boot-mode pin codes (pin1, pin0)
  // ****************************************************************
  localparam logic [1:0] BOOT_SLAVE = 2'h1;
  localparam logic [1:0] BOOT_RUN = 2'h0;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // Synchroniser reset level: chip select and strobes idle high
  localparam logic [14:0] PIN_IDLE = 15'h7000;
endpackage : mailbox_pkg

// File: rtl/slave_port_mailbox_regs.sv
// Overview of operation
// [R1] Each mailbox is two registers: slave-to-master and master-to-slave.
// [R2] Master select 0..2 picks data registers, 3 the status; no control access.
// [R3] Slave I/O: data at 20h-22h, status 23h, control 24h.
// [R4] Concurrent read sees bits change once, monotonically, at most one read.
// [R5] Pollers should double-read or watch one bit.
// [R6] Control bit 7 low obeys boot pins; high makes them plain inputs.
// [R7] Boot pins (0,1) at reset end enter cold boot via data register 0.
// [R8] Pins going to (0,0) end cold boot, run from address zero.
// [R9] Control bits 6,5 read the boot pin levels.
// [R10] Control bit 3 enables slave port, taking pins from port A.
// [R11] Cold boot sets control bit 3 automatically.
// [R12] With bit 3 low, bit 2 sets port A input or output.
// [R13] Control bits 1,0: 00 disables interrupt, else priority 1 to 3.
// [R14] Six full flags: set on write, cleared on reader's read.
// [R15] Data register 0 flags drive slave interrupt and attention output.
// [R16] Master write to data 0 sets inbound interrupt flip-flop.
// [R17] Slave write to data 0 drives attention low; master status write raises it.
// [R18] Status write clears only the writing side's interrupt source.
// [R19] Status layout: 7 attn, 6-4 out full, 3 inbound int, 2-0 in full.
// [R20] Reset clears flags and interrupt sources; attention high.
`timescale 1ns/1ps
`default_nettype none
module slave_port_mailbox_regs
  import mailbox_pkg::*;
#(
  parameter int DEPTH = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Slave internal I/O access
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // Master parallel bus pins
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic select_addr0,
  input wire logic select_addr1,
  input wire logic [7:0] master_data_in,
  output logic [7:0] master_data_out,
  output logic master_data_oe,
  // Boot mode pins
  input wire logic boot_mode_pin0,
  input wire logic boot_mode_pin1,
  // Status toward the processor and pins
  output logic attention_out_n,
  output logic slave_irq,
  output logic [1:0] irq_priority,
  output logic cold_boot_active,
  output logic run_from_zero,
  output logic slave_port_enabled,
  output logic port_a_output,
  output logic boot_pins_obeyed
);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [14:0] pins_raw;
  logic [14:0] pins_s;
  assign pins_raw = {chip_select_n, read_strobe_n, write_strobe_n, select_addr1, select_addr0,
                     master_data_in, boot_mode_pin1, boot_mode_pin0};
  sync2 #(
    .WIDTH(15),
    .INIT(PIN_IDLE)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .d(pins_raw),
    .q(pins_s)
  );
  wire logic cs_n_s = pins_s[14];
  wire logic rd_n_s = pins_s[13];
  wire logic wr_n_s = pins_s[12];
  wire logic [1:0] sel_s = pins_s[11:10];
  wire logic [7:0] mdata_s = pins_s[9:2];
  wire logic [1:0] boot_s = pins_s[1:0];
  // ****************************************************************
  // Master strobe edges
  // ****************************************************************
  logic rd_act_reg;
  logic rd_start_d_reg;
  logic wr_act_reg;
  logic [1:0] wr_sel_reg;
  logic [7:0] wr_data_reg;
  wire logic rd_act = !cs_n_s && !rd_n_s;
  wire logic wr_act = !cs_n_s && !wr_n_s;
  wire logic m_rd_start = rd_act && !rd_act_reg;
  // Write commits when either strobe rises, with data captured while low
  wire logic m_wr_end = !wr_act && wr_act_reg;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_act_reg <= 1'b0;
      rd_start_d_reg <= 1'b0;
      wr_act_reg <= 1'b0;
      wr_sel_reg <= 2'h0;
      wr_data_reg <= DATA_RESET;
    end
    else
    begin
      rd_act_reg <= rd_act;
      rd_start_d_reg <= m_rd_start;
      wr_act_reg <= wr_act;
      if (wr_act)
      begin
        wr_sel_reg <= sel_s;
        wr_data_reg <= mdata_s;
      end
    end
  end
  wire logic m_rd_end = !rd_act && rd_act_reg;
  // ****************************************************************
  // Decode
  // ****************************************************************
  wire logic m_wr_data = m_wr_end && (wr_sel_reg <= SEL_DATA_2); // see [R2]
  wire logic m_wr_flags = m_wr_end && (wr_sel_reg == SEL_FLAGS); // see [R2]
  wire logic m_wr_d0 = m_wr_data && (wr_sel_reg == SEL_DATA_0);
  wire logic s_hit_data = (io_addr >= ADDR_DATA_0) && (io_addr <= ADDR_DATA_2); // see [R3]
  wire logic s_hit_flags = (io_addr == ADDR_FLAGS); // see [R3]
  wire logic s_hit_ctl = (io_addr == ADDR_CONTROL); // see [R3]
  wire logic [1:0] s_idx = 2'(io_addr - ADDR_DATA_0);
  wire logic s_wr_data = io_wr && s_hit_data;
  wire logic s_wr_d0 = s_wr_data && (s_idx == 2'h0);
  wire logic s_rd_data = io_rd && s_hit_data;
  wire logic m_rd_data = m_rd_end && (sel_s <= SEL_DATA_2);
  // ****************************************************************
  // Mailbox banks, one per direction
  // ****************************************************************
  logic [7:0] out_rdata;
  logic [7:0] in_rdata;
  mailbox_bank #(
    .DEPTH(DEPTH),
    .WIDTH(8)
  ) u_outbound (
    .clk(clk),
    .rst(rst),
    .wr_en(s_wr_data), // see [R1]
    .wr_sel(s_idx),
    .wr_data(io_wdata),
    .rd_sel(sel_s),
    .rd_data(out_rdata)
  );
  mailbox_bank #(
    .DEPTH(DEPTH),
    .WIDTH(8)
  ) u_inbound (
    .clk(clk),
    .rst(rst),
    .wr_en(m_wr_data), // see [R1]
    .wr_sel(wr_sel_reg),
    .wr_data(wr_data_reg),
    .rd_sel(s_idx),
    .rd_data(in_rdata)
  );
  // ****************************************************************
  // Full flags and interrupt sources
  // ****************************************************************
  logic [2:0] in_full_reg;
  logic [2:0] out_full_reg;
  logic in_int_reg;
  logic attn_reg;
  logic [2:0] in_set;
  logic [2:0] in_clr;
  logic [2:0] out_set;
  logic [2:0] out_clr;
  genvar i;
  generate
    for (i = 0; i < 3; i++)
    begin : g_flag
      assign in_set[i] = m_wr_data && (wr_sel_reg == 2'(i));
      assign in_clr[i] = s_rd_data && (s_idx == 2'(i));
      assign out_set[i] = s_wr_data && (s_idx == 2'(i));
      assign out_clr[i] = m_rd_data && (sel_s == 2'(i));
    end
  endgenerate
  // Set wins over a clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      in_full_reg <= 3'h0; // see [R20]
      out_full_reg <= 3'h0; // see [R20]
      in_int_reg <= 1'b0; // see [R20]
      attn_reg <= 1'b0; // see [R20]
    end
    else
    begin
      in_full_reg <= in_set | (in_full_reg & ~in_clr); // see [R14]
      out_full_reg <= out_set | (out_full_reg & ~out_clr); // see [R14]
      if (m_wr_d0)
        in_int_reg <= 1'b1; // see [R16]
      else if (io_wr && s_hit_flags)
        in_int_reg <= 1'b0; // see [R18]
      if (s_wr_d0)
        attn_reg <= 1'b1; // see [R17]
      else if (m_wr_flags)
        attn_reg <= 1'b0; // see [R18]
    end
  end
  logic [7:0] flags;
  assign flags = {attn_reg, out_full_reg, in_int_reg, in_full_reg}; // see [R19]
  // ****************************************************************
  // Control register and cold boot
  // ****************************************************************
  logic [7:0] ctl_reg;
  logic boot_reg;
  logic [2:0] release_reg;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctl_reg <= CTL_RESET;
      boot_reg <= 1'b0;
      release_reg <= 3'h7;
    end
    else
    begin
      // Pin level sampled once, third edge after release, when synced pins are valid
      release_reg <= {release_reg[1:0], 1'b0};
      if (release_reg == 3'h4 && !ctl_reg[CTL_IGNORE_PINS] && boot_s == BOOT_SLAVE)
        boot_reg <= 1'b1; // see [R7]
      else if (boot_reg && (ctl_reg[CTL_IGNORE_PINS] || boot_s == BOOT_RUN))
        boot_reg <= 1'b0; // see [R8]
      if (io_wr && s_hit_ctl)
        ctl_reg <= io_wdata & CTL_WRITE_MASK;
      if (release_reg == 3'h4 && !ctl_reg[CTL_IGNORE_PINS] && boot_s == BOOT_SLAVE)
        ctl_reg[CTL_PORT_EN] <= 1'b1; // see [R11]
    end
  end
  logic boot_exit_reg;
  always_ff @(posedge clk)
  begin
    if (rst)
      boot_exit_reg <= 1'b0;
    else
      boot_exit_reg <= boot_reg && (ctl_reg[CTL_IGNORE_PINS] || boot_s == BOOT_RUN); // see [R8]
  end
  logic [7:0] ctl_view;
  assign ctl_view = {ctl_reg[CTL_IGNORE_PINS], boot_s[1], boot_s[0], 1'b0, ctl_reg[3:0]}; // see [R9]
  // ****************************************************************
  // Slave read mux, registered
  // ****************************************************************
  // Bank data is registered, so the answer is taken one cycle after the read
  logic s_rd_pend_reg;
  logic [1:0] s_rd_kind_reg;
  wire logic [1:0] s_rd_kind = s_hit_data ? 2'h1 : s_hit_flags ? 2'h2 : s_hit_ctl ? 2'h3 : 2'h0;
  wire logic [7:0] s_rd_mux = (s_rd_kind_reg == 2'h1) ? in_rdata : (s_rd_kind_reg == 2'h2) ? flags :
                              (s_rd_kind_reg == 2'h3) ? ctl_view : 8'h00;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_rd_pend_reg <= 1'b0;
      s_rd_kind_reg <= 2'h0;
      io_rdata <= 8'h00;
    end
    else
    begin
      s_rd_pend_reg <= io_rd;
      if (io_rd)
        s_rd_kind_reg <= s_rd_kind;
      if (s_rd_pend_reg)
        io_rdata <= s_rd_mux; // see [R1]
    end
  end
  // ****************************************************************
  // Master read data, latched at strobe start and held steady
  // ****************************************************************
  // A single capture keeps each bit monotonic and limits tearing to one read
  wire logic [7:0] m_rd_mux = (sel_s == SEL_FLAGS) ? flags : out_rdata; // see [R2]
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      master_data_out <= 8'h00;
      master_data_oe <= 1'b0;
    end
    else
    begin
      if (rd_start_d_reg)
        master_data_out <= m_rd_mux; // see [R4]
      master_data_oe <= rd_act && ctl_reg[CTL_PORT_EN];
    end
  end
  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign attention_out_n = !attn_reg; // see [R15]
  assign irq_priority = ctl_reg[CTL_PRIO_HI:CTL_PRIO_LO];
  assign slave_irq = in_int_reg && (irq_priority != 2'h0); // see [R13]
  assign cold_boot_active = boot_reg;
  assign run_from_zero = boot_exit_reg;
  assign slave_port_enabled = ctl_reg[CTL_PORT_EN]; // see [R10]
  assign port_a_output = !ctl_reg[CTL_PORT_EN] && ctl_reg[CTL_PORTA_OUT]; // see [R12]
  assign boot_pins_obeyed = !ctl_reg[CTL_IGNORE_PINS]; // see [R6]
endmodule : slave_port_mailbox_regs
`default_nettype wire

// File: rtl/sync2.sv
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_reg <= INIT;
      q <= INIT;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : sync2
`default_nettype wire
